// *** src/cpl_port_pkg.sv ***
// Shared constants for the completion port: descriptor fields, status codes, phases
package cpl_port_pkg;
  localparam int DW_BITS = 32;
  localparam int MAX_DW = 8;
  localparam int DESC_DW = 3;
  localparam int DESC_BYTES = 12;
  localparam int ERR_PKT_BITS = 256;
  // Bit positions inside the three descriptor dwords, and dword indices up to the request info dword 3
  localparam int F_STATUS_LSB = 11;
  localparam int F_STATUS_W = 3;
  localparam int F_DEVFN_LSB = 8;
  localparam int F_BUS_LSB = 16;
  localparam int F_CID_EN = 24;
  localparam int F_FORCE_DIGEST = 31;
  localparam int DW_STATUS = 1;
  localparam int DW_IDS = 2;
  localparam int DW_REQ_INFO = 3;
  // Sideband layout and defaults
  localparam int SB_DISCONTINUE = 0;
  localparam int SB_W_DEFAULT = 33;
  localparam logic [2:0] ST_SUCCESS = 3'h0;
  localparam logic [2:0] ST_UNSUPPORTED = 3'h1;
  localparam logic [2:0] ST_ABORT = 3'h4;
  localparam logic RST_READY = 1'b0;
  localparam logic [11:0] RST_BEATS = 12'h000;
  localparam logic [11:0] BEATS_MAX = 12'hfff;
  typedef enum logic [0:0] {
    PH_IDLE = 1'b0,
    PH_BODY = 1'b1
  } phase_t;
endpackage

// *** src/gather_if.sv ***
// Beat feed into the dword gatherer and the gathered leading dwords back out
`timescale 1ns/10ps
interface gather_if
  import cpl_port_pkg::*;
#(
  parameter int DATA_W = 64
);
  logic beat_en;
  logic beat_first;
  logic [DATA_W-1:0] beat_data;
  logic [31:0] dw [MAX_DW];
  logic [3:0] filled;
  modport feeder(output beat_en, output beat_first, output beat_data, input dw, input filled);
  modport gather(input beat_en, input beat_first, input beat_data, output dw, output filled);
endinterface

// *** src/dword_gather.sv ***
// Captures the first eight dwords of each packet, whatever the beat width
`timescale 1ns/10ps
module dword_gather
  import cpl_port_pkg::*;
#(
  parameter int DATA_W = 64
)(
  input wire logic clk,
  input wire logic rst,
  gather_if.gather g
);
  localparam int DPB = DATA_W / DW_BITS;

  logic [31:0] dw_ff [MAX_DW];
  logic [31:0] nxt_dw [MAX_DW];
  logic [3:0] idx_ff;
  logic [3:0] nxt_idx;

  always_comb
  begin
    int base;
    int j;
    base = g.beat_first ? 0 : int'(idx_ff);
    j = 0;
    nxt_dw = dw_ff;
    nxt_idx = idx_ff;
    if (g.beat_en)
    begin
      for (int i = 0; i < DPB; i++)
      begin
        j = base + i;
        if (j < MAX_DW)
        begin
          nxt_dw[j] = g.beat_data[DW_BITS*i +: DW_BITS];
        end
      end
      // Saturate: dwords past the eighth are payload and never inspected
      nxt_idx = (base + DPB > MAX_DW) ? 4'(MAX_DW) : 4'(base + DPB);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      idx_ff <= 4'h0;
      for (int i = 0; i < MAX_DW; i++)
      begin
        dw_ff[i] <= 32'h0000_0000;
      end
    end
    else
    begin
      idx_ff <= nxt_idx;
      dw_ff <= nxt_dw;
    end
  end

  assign g.dw = dw_ff;
  assign g.filled = idx_ff;
endmodule

// *** src/cpl_port.sv ***
// Completer completion port: accepts completion packets and summarises each TLP
//
// What this block does
// - Port width 64, 128 or 256 bits
// - Dword mode: payload right after twelve descriptor bytes
// - Valid drop mid-packet nullifies the TLP
// - Ready may drop; user holds port stable
// - Address mode: payload starts beat after descriptor
// - Discontinue flag aborts packet; TLP nullified
// - Abort stays latched for the remaining beats
// - Discontinue sampled only when valid and ready
// - Endpoint reports abort as uncorrectable internal error
// - Request info dwords fill the error header log
// - Error completion takes 4, 2 or 1 beats
// - Force-digest bit appends digest to TLP
// - Completer-ID enable selects descriptor bus/device numbers
`timescale 1ns/10ps
module cpl_port
  import cpl_port_pkg::*;
#(
  parameter int DATA_W = 64,
  parameter int SB_W = SB_W_DEFAULT
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic addr_aligned_mode,
  input wire logic endpoint_mode,
  input wire logic ecrc_enable,
  input wire logic [7:0] captured_bus,
  input wire logic [4:0] captured_dev,
  input wire logic link_ready,
  input wire logic cpl_in_valid,
  input wire logic [DATA_W-1:0] cpl_in_data,
  input wire logic cpl_in_last,
  input wire logic [SB_W-1:0] cpl_in_sideband,
  output logic cpl_in_ready,
  output logic cpl_out_valid,
  output logic cpl_out_nullify,
  output logic cpl_out_digest,
  output logic [15:0] cpl_out_cid,
  output logic [2:0] cpl_out_status,
  output logic [11:0] cpl_out_pay_slots,
  output logic cpl_out_malformed,
  output logic aer_internal_err,
  output logic aer_log_valid,
  output logic [159:0] aer_log
);
  import cpl_port_pkg::*;
  localparam int DPB = DATA_W / DW_BITS;
  localparam int DESC_BEATS = (DESC_BYTES * 8 + DATA_W - 1) / DATA_W;
  localparam int ERR_BEATS = ERR_PKT_BITS / DATA_W;
  gather_if #(.DATA_W(DATA_W)) g ();
  dword_gather #(.DATA_W(DATA_W)) u_gather (
    .clk(clk),
    .rst(rst),
    .g(g)
  );
  // Packet tracking state
  phase_t phase_ff;
  phase_t nxt_phase;
  logic ready_ff;
  logic nxt_ready;
  logic drop_ff;
  logic nxt_drop;
  logic abort_ff;
  logic nxt_abort;
  logic [11:0] beats_ff;
  logic [11:0] nxt_beats;
  logic finish_ff;
  logic nxt_finish;
  logic accept, first, disc, end_beat;
  assign accept = cpl_in_valid & ready_ff;
  assign first = accept & (phase_ff == PH_IDLE);
  assign disc = accept & cpl_in_sideband[SB_DISCONTINUE];
  assign end_beat = accept & cpl_in_last;
  assign g.beat_en = accept;
  assign g.beat_first = first;
  assign g.beat_data = cpl_in_data;

  always_comb
  begin
    // Ready is a registered copy of the link's room, so it may fall in any cycle
    nxt_ready = link_ready;
    nxt_phase = phase_ff;
    nxt_drop = drop_ff;
    nxt_abort = abort_ff;
    nxt_beats = beats_ff;
    nxt_finish = end_beat;
    unique case (phase_ff)
      PH_IDLE:
      begin
        if (accept && !cpl_in_last)
        begin
          nxt_phase = PH_BODY;
        end
      end
      PH_BODY:
      begin
        if (end_beat)
        begin
          nxt_phase = PH_IDLE;
        end
      end
    endcase
    if (first)
    begin
      nxt_drop = 1'b0;
      nxt_abort = disc;
      nxt_beats = 12'h001;
    end
    else
    begin
      // Valid falling inside a packet poisons it, even while ready is low
      if (phase_ff == PH_BODY && !cpl_in_valid)
      begin
        nxt_drop = 1'b1;
      end
      // Sticky until the next packet's first beat
      if (disc)
      begin
        nxt_abort = 1'b1;
      end
      if (accept && beats_ff != BEATS_MAX)
      begin
        nxt_beats = beats_ff + 12'h001;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      phase_ff <= PH_IDLE;
      ready_ff <= RST_READY;
      drop_ff <= 1'b0;
      abort_ff <= 1'b0;
      beats_ff <= RST_BEATS;
      finish_ff <= 1'b0;
    end
    else
    begin
      phase_ff <= nxt_phase;
      ready_ff <= nxt_ready;
      drop_ff <= nxt_drop;
      abort_ff <= nxt_abort;
      beats_ff <= nxt_beats;
      finish_ff <= nxt_finish;
    end
  end

  // Descriptor decode, one cycle after the last beat when all leading dwords sit in the gatherer
  logic [2:0] d_status;
  logic d_err, d_cid_en;
  logic [7:0] d_bus;
  logic [7:0] d_devfn;
  assign d_status = g.dw[DW_STATUS][F_STATUS_LSB +: F_STATUS_W];
  assign d_err = (d_status == ST_UNSUPPORTED) || (d_status == ST_ABORT);
  assign d_cid_en = g.dw[DW_IDS][F_CID_EN];
  assign d_bus = g.dw[DW_IDS][F_BUS_LSB +: 8];
  assign d_devfn = g.dw[DW_IDS][F_DEVFN_LSB +: 8];
  // Result registers
  logic out_valid_ff;
  logic out_nullify_ff;
  logic out_digest_ff;
  logic [15:0] out_cid_ff;
  logic [2:0] out_status_ff;
  logic [11:0] out_pay_ff;
  logic out_malformed_ff;
  logic aer_int_ff;
  logic aer_log_valid_ff;
  logic [159:0] aer_log_ff;
  logic nxt_out_valid;
  logic nxt_out_nullify;
  logic nxt_out_digest;
  logic [15:0] nxt_out_cid;
  logic [2:0] nxt_out_status;
  logic [11:0] nxt_out_pay;
  logic nxt_out_malformed;
  logic nxt_aer_int;
  logic nxt_aer_log_valid;
  logic [159:0] nxt_aer_log;

  always_comb
  begin
    nxt_out_valid = finish_ff;
    nxt_out_nullify = out_nullify_ff;
    nxt_out_digest = out_digest_ff;
    nxt_out_cid = out_cid_ff;
    nxt_out_status = out_status_ff;
    nxt_out_pay = out_pay_ff;
    nxt_out_malformed = out_malformed_ff;
    nxt_aer_int = 1'b0;
    nxt_aer_log_valid = 1'b0;
    nxt_aer_log = aer_log_ff;
    if (finish_ff)
    begin
      nxt_out_nullify = drop_ff | abort_ff;
      nxt_out_digest = g.dw[DW_IDS][F_FORCE_DIGEST] | ecrc_enable;
      nxt_out_status = d_status;
      if (!endpoint_mode || d_cid_en)
      begin
        nxt_out_cid = {d_bus, d_devfn};
      end
      else
      begin
        nxt_out_cid = {captured_bus, captured_dev, d_devfn[2:0]};
      end
      // Payload slots: dword mode packs payload after the 3 descriptor dwords,
      // address mode starts it on a fresh beat
      if (d_err)
      begin
        nxt_out_pay = 12'h000;
      end
      else if (addr_aligned_mode)
      begin
        nxt_out_pay = 12'((beats_ff - 12'(DESC_BEATS)) * 12'(DPB));
      end
      else
      begin
        nxt_out_pay = 12'(beats_ff * 12'(DPB) - 12'(DESC_DW));
      end
      nxt_out_malformed = d_err && (beats_ff != 12'(ERR_BEATS));
      nxt_aer_int = endpoint_mode & abort_ff;
      nxt_aer_log_valid = d_err;
      if (d_err)
      begin
        nxt_aer_log = {g.dw[7], g.dw[6], g.dw[5], g.dw[4], g.dw[DW_REQ_INFO]};
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      out_valid_ff <= 1'b0;
      out_nullify_ff <= 1'b0;
      out_digest_ff <= 1'b0;
      out_cid_ff <= 16'h0000;
      out_status_ff <= ST_SUCCESS;
      out_pay_ff <= 12'h000;
      out_malformed_ff <= 1'b0;
      aer_int_ff <= 1'b0;
      aer_log_valid_ff <= 1'b0;
      aer_log_ff <= '0;
    end
    else
    begin
      out_valid_ff <= nxt_out_valid;
      out_nullify_ff <= nxt_out_nullify;
      out_digest_ff <= nxt_out_digest;
      out_cid_ff <= nxt_out_cid;
      out_status_ff <= nxt_out_status;
      out_pay_ff <= nxt_out_pay;
      out_malformed_ff <= nxt_out_malformed;
      aer_int_ff <= nxt_aer_int;
      aer_log_valid_ff <= nxt_aer_log_valid;
      aer_log_ff <= nxt_aer_log;
    end
  end

  assign cpl_in_ready = ready_ff;
  assign cpl_out_valid = out_valid_ff;
  assign cpl_out_nullify = out_nullify_ff;
  assign cpl_out_digest = out_digest_ff;
  assign cpl_out_cid = out_cid_ff;
  assign cpl_out_status = out_status_ff;
  assign cpl_out_pay_slots = out_pay_ff;
  assign cpl_out_malformed = out_malformed_ff;
  assign aer_internal_err = aer_int_ff;
  assign aer_log_valid = aer_log_valid_ff;
  assign aer_log = aer_log_ff;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence valid_gap_s;
    (phase_ff == PH_BODY) && !cpl_in_valid;
  endsequence
  sequence end_beat_s;
    cpl_in_valid && cpl_in_ready && cpl_in_last;
  endsequence
  sequence abort_mid_s;
    cpl_in_valid && cpl_in_ready && cpl_in_sideband[SB_DISCONTINUE] && !cpl_in_last;
  endsequence

  // Starting on the last reset edge would catch ready still held low by reset
  ready_follows_link_a: assert property (!rst && link_ready |=> cpl_in_ready)
    else $error("ready did not follow link room");
  result_after_end_a: assert property (end_beat_s |=> finish_ff ##1 cpl_out_valid)
    else $error("completion result not two cycles after last beat");
  gap_nullifies_a: assert property (valid_gap_s ##1 end_beat_s |-> ##2 cpl_out_nullify)
    else $error("valid gap did not nullify the completion");
  abort_nullifies_a: assert property (
    end_beat_s ##0 cpl_in_sideband[SB_DISCONTINUE] |-> ##2 (cpl_out_valid && cpl_out_nullify))
    else $error("discontinue on last beat did not nullify");
  abort_sticky_a: assert property (
    abort_mid_s ##1 (end_beat_s ##0 !cpl_in_sideband[SB_DISCONTINUE]) |-> ##2 cpl_out_nullify)
    else $error("abort not held to packet end");
  clean_not_null_a: assert property (
    end_beat_s ##0 (phase_ff == PH_IDLE && !cpl_in_sideband[SB_DISCONTINUE])
    |-> ##2 !cpl_out_nullify)
    else $error("clean single beat packet was nullified");
  internal_err_a: assert property (
    end_beat_s ##0 (cpl_in_sideband[SB_DISCONTINUE] && endpoint_mode) ##1 endpoint_mode
    |-> ##1 aer_internal_err)
    else $error("endpoint abort not reported");
  digest_forced_a: assert property (
    finish_ff && g.dw[DW_IDS][F_FORCE_DIGEST] |=> cpl_out_valid && cpl_out_digest)
    else $error("forced digest missing");
  cid_select_a: assert property (
    finish_ff && (!endpoint_mode || d_cid_en) |=> cpl_out_cid[15:8] == $past(d_bus))
    else $error("completer bus not taken from descriptor");
  header_log_a: assert property (
    finish_ff && d_err |=> aer_log_valid && aer_log[31:0] == $past(g.dw[DW_REQ_INFO]))
    else $error("header log not filled from request info");
  error_beats_a: assert property (
    finish_ff && d_err && beats_ff == 12'(ERR_BEATS) |=> !cpl_out_malformed)
    else $error("well formed error completion flagged");
  info_gathered_a: assert property (
    finish_ff && d_err && beats_ff == 12'(ERR_BEATS) |-> g.filled == 4'(MAX_DW))
    else $error("error completion request info not fully gathered");
endmodule

// *** verification/cpl_source.sv ***
// User-side source model that pushes completion beats into the port
`timescale 1ns/10ps
module cpl_source (
  input wire logic clk,
  input wire logic ready,
  output logic valid,
  output logic [63:0] data,
  output logic last,
  output logic [32:0] sb
);
  logic [31:0] mem [16];
  initial
  begin
    valid = 1'b0;
    data = 64'h0000_0000_0000_0000;
    last = 1'b0;
    sb = 33'h0_0000_0000;
  end
  // Beat gap drops valid before that beat, beat disc raises discontinue; 99 means never
  task automatic send(input int beats, input int gap, input int disc, input bit hold);
    for (int b = 0; b < beats; b++)
    begin
      @(negedge clk);
      if (b == gap)
      begin
        valid = 1'b0;
        data = ~data;
        @(negedge clk);
      end
      valid = 1'b1;
      data = {mem[2*b+1], mem[2*b]};
      last = (b == beats - 1);
      sb = {32'h0000_0000, b == disc};
      @(posedge clk);
      // Everything stays put until the beat is taken
      while (ready !== 1'b1)
        @(posedge clk);
    end
    if (!hold)
    begin
      @(negedge clk);
      valid = 1'b0;
      // Released data shows the inverse so a stale beat cannot pass for a live one
      data = ~data;
      last = 1'b0;
      sb = 33'h0_0000_0000;
    end
  endtask
endmodule

// *** verification/test_cpl_port.sv ***
// Self-checking bench for the completion port, driven through the source model
`timescale 1ns/10ps
module test_cpl_port;
  import cpl_port_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic addr_aligned_mode = 1'b0;
  logic endpoint_mode = 1'b1;
  logic ecrc_enable = 1'b0;
  logic [7:0] captured_bus = 8'h3c;
  logic [4:0] captured_dev = 5'h0a;
  logic link_ready = 1'b0;
  logic stall = 1'b0;
  logic valid, last, ready, o_valid, nullify, digest, malformed, int_err, log_valid;
  logic [63:0] data;
  logic [32:0] sb;
  logic [15:0] cid;
  logic [2:0] status;
  logic [11:0] slots;
  logic [159:0] log;
  int fail_count = 0;
  int comparisons = 0;
  always #4 clk = ~clk;
  // Stalling toggles the link side so the port refuses every other cycle
  always @(negedge clk) link_ready <= stall ? ~link_ready : 1'b1;
  cpl_source src (.clk(clk), .ready(ready), .valid(valid), .data(data), .last(last), .sb(sb));
  cpl_port #(.DATA_W(64), .SB_W(33)) dut (.clk(clk), .rst(rst),
    .addr_aligned_mode(addr_aligned_mode), .endpoint_mode(endpoint_mode),
    .ecrc_enable(ecrc_enable), .captured_bus(captured_bus), .captured_dev(captured_dev),
    .link_ready(link_ready), .cpl_in_valid(valid), .cpl_in_data(data), .cpl_in_last(last),
    .cpl_in_sideband(sb), .cpl_in_ready(ready), .cpl_out_valid(o_valid),
    .cpl_out_nullify(nullify), .cpl_out_digest(digest), .cpl_out_cid(cid),
    .cpl_out_status(status), .cpl_out_pay_slots(slots), .cpl_out_malformed(malformed),
    .aer_internal_err(int_err), .aer_log_valid(log_valid), .aer_log(log));
  task print_verdict;
    if (fail_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input string name, input logic [159:0] got, input logic [159:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task desc(input logic [2:0] st, input bit force_dg, input bit cen);
    for (int i = 0; i < 16; i++)
      src.mem[i] = 32'ha5c3_0000 + 32'(i);
    src.mem[1] = {18'h0_0000, st, 11'h000};
    src.mem[2] = {force_dg, 6'h00, cen, 8'h5a, 8'h93, 8'h00};
  endtask
  // Result pulse stands in the second cycle after the last beat; release used the first negedge
  task result;
    @(negedge clk);
    chk("out_valid", o_valid, 1'b1);
  endtask
  initial
  begin
    #100000;
    fail_count++;
    print_verdict;
  end
  initial
  begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    chk("reset_ready", ready, 1'b0);
    chk("reset_out_valid", o_valid, 1'b0);
    desc(ST_UNSUPPORTED, 1'b0, 1'b0);
    src.mem[3] = 32'h0000_5a3f;
    src.send(4, 99, 99, 1'b0);
    result;
    chk("ur_status", status, ST_UNSUPPORTED);
    chk("ur_log_valid", log_valid, 1'b1);
    chk("ur_log", log, {src.mem[7], src.mem[6], src.mem[5], src.mem[4], src.mem[3]});
    chk("ur_slots", slots, 12'h000);
    chk("ur_malformed", malformed, 1'b0);
    chk("ready_up", ready, 1'b1);
    desc(ST_ABORT, 1'b0, 1'b0);
    src.send(3, 99, 99, 1'b0);
    result;
    chk("ca_malformed", malformed, 1'b1);
    chk("ca_status", status, ST_ABORT);
    chk("ca_log_valid", log_valid, 1'b1);
    desc(ST_SUCCESS, 1'b1, 1'b0);
    src.send(4, 99, 99, 1'b0);
    result;
    chk("sc_slots", slots, 12'h005);
    chk("sc_digest", digest, 1'b1);
    chk("sc_cid", cid, 16'h3c53);
    chk("sc_nullify", nullify, 1'b0);
    chk("sc_log_valid", log_valid, 1'b0);
    addr_aligned_mode = 1'b1;
    desc(ST_SUCCESS, 1'b0, 1'b1);
    src.send(5, 99, 99, 1'b1);
    fork
      src.send(4, 99, 99, 1'b0);
      begin
        repeat (2) @(negedge clk);
        chk("b2b_first", o_valid, 1'b1);
        chk("aa_slots", slots, 12'h006);
        chk("aa_cid", cid, 16'h5a93);
        chk("aa_digest", digest, 1'b0);
      end
    join
    result;
    chk("aa_slots_second", slots, 12'h004);
    addr_aligned_mode = 1'b0;
    desc(ST_SUCCESS, 1'b0, 1'b0);
    src.send(4, 3, 99, 1'b0);
    result;
    chk("gap_nullify", nullify, 1'b1);
    chk("gap_int_err", int_err, 1'b0);
    stall = 1'b1;
    src.send(4, 99, 1, 1'b0);
    stall = 1'b0;
    result;
    chk("abort_nullify", nullify, 1'b1);
    chk("abort_int_err", int_err, 1'b1);
    chk("stall_slots", slots, 12'h005);
    src.send(4, 99, 99, 1'b0);
    result;
    chk("fresh_nullify", nullify, 1'b0);
    chk("fresh_int_err", int_err, 1'b0);
    src.send(1, 99, 0, 1'b0);
    result;
    chk("lone_abort_nullify", nullify, 1'b1);
    chk("lone_abort_int_err", int_err, 1'b1);
    src.send(1, 99, 99, 1'b0);
    result;
    chk("lone_nullify", nullify, 1'b0);
    endpoint_mode = 1'b0;
    ecrc_enable = 1'b1;
    desc(ST_SUCCESS, 1'b0, 1'b0);
    src.send(4, 99, 2, 1'b0);
    result;
    chk("root_cid", cid, 16'h5a93);
    chk("root_digest", digest, 1'b1);
    chk("root_nullify", nullify, 1'b1);
    chk("root_int_err", int_err, 1'b0);
    chk("root_slots", slots, 12'h005);
    print_verdict;
  end
endmodule
